// *** logic/dape_top.sv ***
// Supervisory diagnostics and serial programming entry for the sensor.
`timescale 1ns/100ps
`include "dape_map.svh"

module dape_top
#(
    parameter int unsigned OV_FILTER_CYCLES = `DAPE_OV_FILTER_CYC,
    parameter int unsigned UV_FILTER_CYCLES = `DAPE_UV_FILTER_CYC
)
(
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM register slave.
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Analog comparator and monitor pins, asynchronous to clk.
    input wire logic supplyOverLevel,
    input wire logic supplyUnderLevel,
    input wire logic porLowLevel,
    input wire logic brokenWire,
    input wire logic eccUncorrectable,
    // Front-end samples on clk.
    input wire logic [11:0] sensorCode,
    input wire logic [11:0] currentCode,
    input wire logic [11:0] tempCode,
    // Decoded serial commands on clk.
    input wire logic cmdValid,
    input wire logic cmdRead,
    input wire logic cmdPort,
    input wire logic cmdCrcOk,
    input wire logic [5:0] cmdAddr,
    input wire logic [31:0] cmdData,
    // Serial replies toward the frame encoder.
    output logic replyValid,
    output logic replyPort,
    output logic [31:0] replyData,
    // Analog output pin control.
    output logic voutOe,
    output logic voutGnd,
    output logic [11:0] voutCode,
    output logic commMode,
    // Open-drain fault pin.
    output logic faultOut,
    output logic faultOe
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [4:0] pinRaw;
    logic [4:0] pinMeta_ff;
    logic [4:0] pinSync_ff;

    assign pinRaw = {eccUncorrectable, brokenWire, porLowLevel,
                     supplyUnderLevel, supplyOverLevel};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_sync
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pinMeta_ff[gi] <= 1'b0;
                    pinSync_ff[gi] <= 1'b0;
                end
                else
                begin
                    pinMeta_ff[gi] <= pinRaw[gi];
                    pinSync_ff[gi] <= pinMeta_ff[gi];
                end
            end
        end
    endgenerate

    logic ovLevel;
    logic uvLevel;
    logic porLow;
    logic broken;
    logic eccErr;
    logic ovHeld;
    logic uvHeld;

    assign ovLevel = pinSync_ff[0];
    assign uvLevel = pinSync_ff[1];
    assign porLow = pinSync_ff[2];
    assign broken = pinSync_ff[3];
    assign eccErr = pinSync_ff[4];

    dape_hold_filter #(.CYCLES(OV_FILTER_CYCLES)) u_ovFilter
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(ovLevel),
        .held(ovHeld)
    );

    dape_hold_filter #(.CYCLES(UV_FILTER_CYCLES)) u_uvFilter
    (
        .clk(clk),
        .rst_n(rst_n),
        .level(uvLevel),
        .held(uvHeld)
    );

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [3:0] ctrl_ff;
    logic [11:0] ocThr_ff;
    logic [11:0] otThr_ff;
    logic [11:0] clpLo_ff;
    logic [11:0] clpHi_ff;
    logic waitreq_ff;
    logic [31:0] readdata_ff;
    logic busReq;
    logic busDone;
    logic [31:0] statusWord;
    logic [31:0] nxt_readdata;

    logic commLock;
    assign commLock = ctrl_ff[`DAPE_CTRL_COMM_LOCK];

    // One wait cycle: the request is answered on the second edge.
    assign busReq = read || write;
    assign busDone = busReq && !waitreq_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            waitreq_ff <= 1'b1;
        else
            waitreq_ff <= !(busReq && waitreq_ff);
    end

    always_comb
    begin
        case (address)
            `DAPE_REG_CTRL: nxt_readdata = {28'h0, ctrl_ff};
            `DAPE_REG_OC_THR: nxt_readdata = {20'h0, ocThr_ff};
            `DAPE_REG_OT_THR: nxt_readdata = {20'h0, otThr_ff};
            `DAPE_REG_CLP_LO: nxt_readdata = {20'h0, clpLo_ff};
            `DAPE_REG_CLP_HI: nxt_readdata = {20'h0, clpHi_ff};
            `DAPE_REG_STATUS: nxt_readdata = statusWord;
            default: nxt_readdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            readdata_ff <= 32'h0;
        else if (read && waitreq_ff)
            readdata_ff <= nxt_readdata;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff <= `DAPE_CTRL_RST;
            ocThr_ff <= `DAPE_THR_RST;
            otThr_ff <= `DAPE_THR_RST;
            clpLo_ff <= `DAPE_CLP_LO_RST;
            clpHi_ff <= `DAPE_CLP_HI_RST;
        end
        else if (busDone && write)
        begin
            case (address)
                `DAPE_REG_CTRL: ctrl_ff <= writedata[3:0];
                `DAPE_REG_OC_THR: ocThr_ff <= writedata[11:0];
                `DAPE_REG_OT_THR: otThr_ff <= writedata[11:0];
                `DAPE_REG_CLP_LO: clpLo_ff <= writedata[11:0];
                `DAPE_REG_CLP_HI: clpHi_ff <= writedata[11:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Access code handling
    // ****************************************************************
    logic accessWrite;
    logic codeGood;
    logic voutCmd;
    logic progCmd;

    assign accessWrite = cmdValid && cmdCrcOk && !cmdRead
                         && (cmdAddr == `DAPE_ACCESS_ADDR);
    assign codeGood = (cmdData[31:1] == 31'(`DAPE_ACCESS_CODE >> 1));
    assign voutCmd = cmdPort == dape_pkg::PORT_OUTPIN;
    assign progCmd = cmdPort == dape_pkg::PORT_PGMPIN;

    dape_pkg::dape_vstate_t vState_ff;
    dape_pkg::dape_vstate_t nxt_vState;
    logic voutOpen_ff;
    logic progOpen_ff;
    logic holdComm_ff;

    always_comb
    begin
        nxt_vState = vState_ff;
        case (vState_ff)
            dape_pkg::VS_ANALOG:
                if (ovHeld && !commLock)
                    nxt_vState = dape_pkg::VS_OVWAIT;
            // No timer here: the wait lasts as long as overvoltage does.
            dape_pkg::VS_OVWAIT:
                if (commLock)
                    nxt_vState = dape_pkg::VS_ANALOG;
                else if (accessWrite && voutCmd && !codeGood)
                    nxt_vState = dape_pkg::VS_LOCKED;
                else if (accessWrite && voutCmd && cmdData[0])
                    nxt_vState = dape_pkg::VS_COMM;
                else if (!ovHeld)
                    nxt_vState = dape_pkg::VS_ANALOG;
            dape_pkg::VS_COMM: nxt_vState = dape_pkg::VS_COMM;
            dape_pkg::VS_LOCKED: nxt_vState = dape_pkg::VS_LOCKED;
            default: nxt_vState = dape_pkg::VS_ANALOG;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            vState_ff <= dape_pkg::VS_ANALOG;
        else
            vState_ff <= nxt_vState;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            voutOpen_ff <= 1'b0;
        else if (nxt_vState == dape_pkg::VS_ANALOG
                 || nxt_vState == dape_pkg::VS_LOCKED)
            voutOpen_ff <= 1'b0;
        else if (accessWrite && voutCmd && codeGood
                 && vState_ff == dape_pkg::VS_OVWAIT)
            voutOpen_ff <= 1'b1;
    end

    // The program pin needs no overvoltage and ignores the lock.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            progOpen_ff <= 1'b0;
        else if (accessWrite && progCmd && codeGood)
            progOpen_ff <= 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            holdComm_ff <= 1'b0;
        else if (accessWrite && codeGood && cmdData[0]
                 && (progCmd || vState_ff == dape_pkg::VS_OVWAIT))
            holdComm_ff <= 1'b1;
    end

    // ****************************************************************
    // Serial replies
    // ****************************************************************
    logic portOpen;
    logic replyValid_ff;
    logic replyPort_ff;
    logic [31:0] replyData_ff;

    assign portOpen = voutCmd ? voutOpen_ff : progOpen_ff;

    // Replies come only from an accepted read; writes stay silent.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            replyValid_ff <= 1'b0;
            replyPort_ff <= 1'b0;
            replyData_ff <= 32'h0;
        end
        else
        begin
            replyValid_ff <= cmdValid && cmdRead && cmdCrcOk && portOpen;
            if (cmdValid && cmdRead && cmdCrcOk && portOpen)
            begin
                replyPort_ff <= cmdPort;
                replyData_ff <= {4'h0,
                    eccErr ? `DAPE_ECC_UNCORR : `DAPE_ECC_OK,
                    statusWord[25:0]};
            end
        end
    end

    // ****************************************************************
    // Output pin and fault decisions
    // ****************************************************************
    logic ocHit;
    logic otHit;
    logic pinsOff;
    logic analogOff;
    logic uvWins;
    logic [11:0] clampedCode;
    logic voutOe_ff;
    logic voutGnd_ff;
    logic [11:0] voutCode_ff;
    logic faultOe_ff;
    logic faultOut_ff;

    assign ocHit = ctrl_ff[`DAPE_CTRL_OC_EN] && currentCode >= ocThr_ff;
    assign otHit = ctrl_ff[`DAPE_CTRL_OT_EN] && tempCode >= otThr_ff;
    // Broken wire, bad memory and brown-out release both pins.
    assign pinsOff = porLow || broken || eccErr;
    assign analogOff = holdComm_ff || vState_ff == dape_pkg::VS_OVWAIT
                       || vState_ff == dape_pkg::VS_COMM;
    assign uvWins = uvHeld && !pinsOff && !analogOff;

    always_comb
    begin
        clampedCode = sensorCode;
        if (ctrl_ff[`DAPE_CTRL_CLAMP_EN])
        begin
            if (sensorCode < clpLo_ff)
                clampedCode = clpLo_ff;
            else if (sensorCode > clpHi_ff)
                clampedCode = clpHi_ff;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            voutOe_ff <= 1'b0;
            voutGnd_ff <= 1'b0;
        end
        else
        begin
            // Clearing pinsOff re-enables the output at once unless uvHeld or analogOff keeps it off.
            voutOe_ff <= !pinsOff && !analogOff && !uvHeld;
            voutGnd_ff <= uvWins;
        end
    end

    // Freezing the code ignores the field while the wire is open.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            voutCode_ff <= 12'h0;
        else if (!pinsOff)
            voutCode_ff <= clampedCode;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            faultOe_ff <= 1'b0;
            faultOut_ff <= 1'b0;
        end
        else
        begin
            faultOe_ff <= (ocHit || otHit) && !pinsOff && !uvHeld
                          && vState_ff != dape_pkg::VS_OVWAIT;
            faultOut_ff <= 1'b0;
        end
    end

    // Registered so the pin-facing flag cannot glitch between its sources.
    logic commMode_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            commMode_ff <= 1'b0;
        else
            commMode_ff <= holdComm_ff || voutOpen_ff || progOpen_ff;
    end

    assign statusWord = {20'h0, vState_ff, holdComm_ff, progOpen_ff,
                         otHit, ocHit, eccErr, broken, porLow, uvHeld,
                         ovHeld, voutOpen_ff};

    assign readdata = readdata_ff;
    assign waitrequest = waitreq_ff;
    assign replyValid = replyValid_ff;
    assign replyPort = replyPort_ff;
    assign replyData = replyData_ff;
    assign voutOe = voutOe_ff;
    assign voutGnd = voutGnd_ff;
    assign voutCode = voutCode_ff;
    assign commMode = commMode_ff;
    assign faultOut = faultOut_ff;
    assign faultOe = faultOe_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ov_release_pins_a: assert property (
        vState_ff == dape_pkg::VS_OVWAIT |=> !voutOe_ff && !faultOe_ff)
        else $error("Output or fault driven during overvoltage.");

    uv_ground_a: assert property (
        uvWins |=> voutGnd_ff && !voutOe_ff)
        else $error("Undervoltage did not ground the output.");

    lock_ignores_ov_a: assert property (
        commLock && vState_ff == dape_pkg::VS_ANALOG
        |=> vState_ff == dape_pkg::VS_ANALOG)
        else $error("Overvoltage acted while locked.");

    oc_fault_low_a: assert property (
        ocHit && !pinsOff && !uvHeld && vState_ff == dape_pkg::VS_ANALOG
        |=> faultOe_ff)
        else $error("Overcurrent did not assert fault.");

    ecc_both_hiz_a: assert property (
        eccErr |=> !voutOe_ff && !faultOe_ff)
        else $error("Memory error left a pin driven.");

    broken_recover_a: assert property (
        $fell(broken) && !porLow && !eccErr && !uvHeld && !analogOff
        |=> voutOe_ff)
        else $error("Output did not resume after reconnection.");

    reply_after_read_a: assert property (
        replyValid_ff |-> $past(cmdValid && cmdRead))
        else $error("Reply without a read command.");

    wrong_code_lock_a: assert property (
        vState_ff == dape_pkg::VS_LOCKED
        |=> vState_ff == dape_pkg::VS_LOCKED ##1 !voutOpen_ff)
        else $error("Locked output pin left its lock.");

    hold_comm_stays_a: assert property (
        holdComm_ff |=> holdComm_ff && !voutOe_ff)
        else $error("Held communication mode was lost.");

    clamp_limit_a: assert property (
        ctrl_ff[`DAPE_CTRL_CLAMP_EN] && !pinsOff && clpLo_ff <= clpHi_ff
        |=> voutCode_ff >= $past(clpLo_ff) && voutCode_ff <= $past(clpHi_ff))
        else $error("Output code outside the clamps.");

    ov_entry_c: cover property (
        vState_ff == dape_pkg::VS_ANALOG ##1
        vState_ff == dape_pkg::VS_OVWAIT);
    comm_hold_c: cover property (vState_ff == dape_pkg::VS_COMM);
    wrong_code_c: cover property (vState_ff == dape_pkg::VS_LOCKED);
    fault_c: cover property (faultOe_ff && voutOe_ff);

endmodule

// *** logic/dape_map.svh ***
// Constants for the diagnostics and program entry block.
`ifndef DAPE_MAP_SVH
`define DAPE_MAP_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define DAPE_CLK_MHZ 250
`define DAPE_OV_FILTER_US 64
`define DAPE_UV_FILTER_US 64
`define DAPE_OV_FILTER_CYC (`DAPE_OV_FILTER_US * `DAPE_CLK_MHZ)
`define DAPE_UV_FILTER_CYC (`DAPE_UV_FILTER_US * `DAPE_CLK_MHZ)

// ****************************************************************
// Register word offsets (byte address is four times the offset)
// ****************************************************************
`define DAPE_REG_CTRL 4'h0
`define DAPE_REG_OC_THR 4'h1
`define DAPE_REG_OT_THR 4'h2
`define DAPE_REG_CLP_LO 4'h3
`define DAPE_REG_CLP_HI 4'h4
`define DAPE_REG_STATUS 4'h5

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define DAPE_CTRL_COMM_LOCK 0
`define DAPE_CTRL_OC_EN 1
`define DAPE_CTRL_OT_EN 2
`define DAPE_CTRL_CLAMP_EN 3
`define DAPE_CTRL_RST 4'h0
`define DAPE_THR_RST 12'hfff
`define DAPE_CLP_LO_RST 12'h000
`define DAPE_CLP_HI_RST 12'hfff

// ****************************************************************
// Serial access code
// ****************************************************************
`define DAPE_ACCESS_ADDR 6'h31
`define DAPE_ACCESS_CODE 32'h2c413736
`define DAPE_ECC_UNCORR 2'h2
`define DAPE_ECC_OK 2'h0

`endif

// *** logic/dape_pkg.sv ***
// Types shared by the diagnostics and program entry block.
package dape_pkg;

    // Output pin programming state, Gray coded along the usual path.
    typedef enum logic [1:0]
    {
        VS_ANALOG = 2'h0,
        VS_OVWAIT = 2'h1,
        VS_COMM   = 2'h3,
        VS_LOCKED = 2'h2
    } dape_vstate_t;

    // Which pin a decoded serial command arrived on.
    typedef enum logic
    {
        PORT_OUTPIN = 1'b0,
        PORT_PGMPIN = 1'b1
    } dape_port_t;

endpackage

// *** logic/dape_hold_filter.sv ***
// Level filter: asserts once its input has stayed high for CYCLES clocks.
`timescale 1ns/100ps

module dape_hold_filter
#(
    parameter int unsigned CYCLES = 16000
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic level,
    output logic held
);

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

    logic [CW-1:0] count_ff;
    logic held_ff;

    // Any dip restarts the count, so a glitchy supply never trips it.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_ff <= '0;
        else if (!level)
            count_ff <= '0;
        else if (count_ff != LIMIT)
            count_ff <= count_ff + CW'(1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            held_ff <= 1'b0;
        else
            held_ff <= level && (count_ff == LIMIT);
    end

    assign held = held_ff;

endmodule

// *** verif/dape_ctrl_model.sv ***
// Programming controller model that issues decoded serial commands.
`timescale 1ns/100ps

module dape_ctrl_model
(
    input wire logic clk,
    output logic cmdValid,
    output logic cmdRead,
    output logic cmdPort,
    output logic cmdCrcOk,
    output logic [5:0] cmdAddr,
    output logic [31:0] cmdData,
    input wire logic replyValid,
    input wire logic replyPort,
    input wire logic [31:0] replyData
);
    int replyCount = 0;
    logic [31:0] lastReply = 32'h0;
    logic lastPort = 1'b0;

    initial
    begin
        cmdValid = 1'b0;
        cmdRead = 1'b0;
        cmdPort = 1'b0;
        cmdCrcOk = 1'b0;
        cmdAddr = 6'h0;
        cmdData = 32'h0;
    end

    // One whole frame per call; the controller alone opens transfers.
    task automatic sendCmd(input logic rd, input logic port,
                           input logic [5:0] addr, input logic [31:0] data);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdRead <= rd;
        cmdPort <= port;
        cmdCrcOk <= 1'b1;
        cmdAddr <= addr;
        cmdData <= data;
        @(posedge clk);
        cmdValid <= 1'b0;
        // Released lines show the inverse so a stale frame never looks valid.
        cmdAddr <= ~addr;
        cmdData <= ~data;
        cmdCrcOk <= 1'b0;
    endtask

    always @(posedge clk)
    begin
        if (replyValid === 1'b1)
        begin
            replyCount++;
            lastReply = replyData;
            lastPort = replyPort;
        end
    end
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the diagnostics and program entry block.
`timescale 1ns/100ps
`include "dape_map.svh"

module testbench;
    localparam int unsigned FILT = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic supplyOverLevel = 1'b0;
    logic supplyUnderLevel = 1'b0;
    logic porLowLevel = 1'b0;
    logic brokenWire = 1'b0;
    logic eccUncorrectable = 1'b0;
    logic [11:0] sensorCode = 12'h0;
    logic [11:0] currentCode = 12'h0;
    logic [11:0] tempCode = 12'h0;
    logic cmdValid, cmdRead, cmdPort, cmdCrcOk;
    logic [5:0] cmdAddr;
    logic [31:0] cmdData, replyData, rd;
    logic replyValid, replyPort, voutOe, voutGnd, commMode;
    logic faultOut, faultOe;
    logic [11:0] voutCode;
    int errors = 0;
    int samples_checked = 0;
    int base;

    initial
    begin
        forever #2 clk = ~clk;
    end

    dape_top #(.OV_FILTER_CYCLES(FILT), .UV_FILTER_CYCLES(FILT)) DUT
    (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .supplyOverLevel(supplyOverLevel),
        .supplyUnderLevel(supplyUnderLevel), .porLowLevel(porLowLevel),
        .brokenWire(brokenWire), .eccUncorrectable(eccUncorrectable),
        .sensorCode(sensorCode), .currentCode(currentCode),
        .tempCode(tempCode), .cmdValid(cmdValid), .cmdRead(cmdRead),
        .cmdPort(cmdPort), .cmdCrcOk(cmdCrcOk), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .replyValid(replyValid), .replyPort(replyPort),
        .replyData(replyData), .voutOe(voutOe), .voutGnd(voutGnd),
        .voutCode(voutCode), .commMode(commMode), .faultOut(faultOut),
        .faultOe(faultOe)
    );

    dape_ctrl_model ctrl
    (
        .clk(clk), .cmdValid(cmdValid), .cmdRead(cmdRead),
        .cmdPort(cmdPort), .cmdCrcOk(cmdCrcOk), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .replyValid(replyValid),
        .replyPort(replyPort), .replyData(replyData)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0)
        begin
            errors++;
            finish_test();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic doReset();
        rst_n <= 1'b0;
        supplyOverLevel <= 1'b0;
        supplyUnderLevel <= 1'b0;
        porLowLevel <= 1'b0;
        brokenWire <= 1'b0;
        eccUncorrectable <= 1'b0;
        sensorCode <= 12'h0;
        currentCode <= 12'h0;
        tempCode <= 12'h0;
        tick(2);
        rst_n <= 1'b1;
        tick(4);
    endtask

    task automatic sendCode(input logic port, input logic [31:0] code);
        ctrl.sendCmd(1'b0, port, `DAPE_ACCESS_ADDR, code);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        doReset();
        bus(1'b0, `DAPE_REG_OC_THR, 32'h0);
        check("ocThr", rd, 32'hfff);
        bus(1'b1, 4'h9, 32'hffff_ffff);
        bus(1'b0, 4'h9, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask

    task automatic t_fault();
        doReset();
        bus(1'b1, `DAPE_REG_CTRL, 32'h6);
        bus(1'b1, `DAPE_REG_OC_THR, 32'h200);
        bus(1'b1, `DAPE_REG_OT_THR, 32'h300);
        currentCode <= 12'h200;
        tick(4);
        check("ocFault", {faultOe, faultOut, voutOe}, 3'b101);
        currentCode <= 12'h1ff;
        tempCode <= 12'h300;
        tick(4);
        check("otFault", {faultOe, voutOe}, 2'b11);
        bus(1'b1, `DAPE_REG_CTRL, 32'h2);
        tick(3);
        check("otOff", faultOe, 1'b0);
    endtask

    task automatic t_clamp();
        doReset();
        bus(1'b1, `DAPE_REG_CLP_LO, 32'h10);
        bus(1'b1, `DAPE_REG_CLP_HI, 32'h20);
        bus(1'b1, `DAPE_REG_CTRL, 32'h8);
        sensorCode <= 12'h5;
        tick(4);
        check("clampLo", voutCode, 12'h10);
        sensorCode <= 12'h7ff;
        tick(4);
        check("clampHi", {faultOe, voutCode}, 13'h0020);
    endtask

    task automatic t_ov();
        doReset();
        bus(1'b1, `DAPE_REG_CTRL, 32'h2);
        bus(1'b1, `DAPE_REG_OC_THR, 32'h0);
        supplyOverLevel <= 1'b1;
        tick(FILT / 2);
        check("ovEarly", voutOe, 1'b1);
        tick(FILT);
        check("ovHiZ", {voutOe, faultOe}, 2'b00);
        base = ctrl.replyCount;
        ctrl.sendCmd(1'b1, 1'b0, 6'h0, 32'h0);
        tick(300);
        sendCode(1'b0, `DAPE_ACCESS_CODE);
        ctrl.sendCmd(1'b1, 1'b0, 6'h0, 32'h0);
        ctrl.sendCmd(1'b0, 1'b0, 6'h2, 32'h5);
        tick(3);
        check("replies", ctrl.replyCount, base + 1);
        check("replyPort", ctrl.lastPort, 1'b0);
        check("ecc", ctrl.lastReply[27:26], `DAPE_ECC_OK);
        supplyOverLevel <= 1'b0;
        tick(8);
        check("analogBack", {voutOe, faultOe}, 2'b11);
    endtask

    task automatic t_wrong();
        doReset();
        supplyOverLevel <= 1'b1;
        tick(FILT + 6);
        sendCode(1'b0, `DAPE_ACCESS_CODE ^ 32'h2);
        tick(3);
        check("wrongAnalog", voutOe, 1'b1);
        base = ctrl.replyCount;
        ctrl.sendCmd(1'b1, 1'b0, 6'h0, 32'h0);
        supplyOverLevel <= 1'b0;
        tick(5);
        supplyOverLevel <= 1'b1;
        tick(FILT + 6);
        check("wrongLocked", voutOe, 1'b1);
        check("wrongSilent", ctrl.replyCount - base, 32'h0);
    endtask

    task automatic t_lock();
        doReset();
        bus(1'b1, `DAPE_REG_CTRL, 32'h1);
        supplyOverLevel <= 1'b1;
        tick(FILT + 6);
        check("lockOv", voutOe, 1'b1);
        base = ctrl.replyCount;
        sendCode(1'b0, `DAPE_ACCESS_CODE);
        ctrl.sendCmd(1'b1, 1'b0, 6'h0, 32'h0);
        tick(3);
        check("lockRefused", ctrl.replyCount, base);
    endtask

    task automatic t_comm();
        doReset();
        base = ctrl.replyCount;
        sendCode(1'b1, `DAPE_ACCESS_CODE | 32'h1);
        ctrl.sendCmd(1'b1, 1'b1, 6'h0, 32'h0);
        tick(3);
        check("progComm", {commMode, voutOe}, 2'b10);
        check("progReply", ctrl.replyCount, base + 1);
        check("progPort", ctrl.lastPort, 1'b1);
        doReset();
        check("commCleared", commMode, 1'b0);
        supplyOverLevel <= 1'b1;
        tick(FILT + 6);
        sendCode(1'b0, `DAPE_ACCESS_CODE | 32'h1);
        supplyOverLevel <= 1'b0;
        tick(FILT);
        check("commHeld", {commMode, voutOe}, 2'b10);
    endtask

    task automatic t_pins();
        doReset();
        bus(1'b1, `DAPE_REG_CTRL, 32'h2);
        bus(1'b1, `DAPE_REG_OC_THR, 32'h0);
        eccUncorrectable <= 1'b1;
        tick(5);
        check("eccHiZ", {voutOe, faultOe}, 2'b00);
        eccUncorrectable <= 1'b0;
        brokenWire <= 1'b1;
        sensorCode <= 12'h123;
        tick(5);
        check("brokenHiZ", {voutOe, faultOe, voutCode}, 14'h0);
        brokenWire <= 1'b0;
        tick(5);
        check("resumed", {voutOe, faultOe, voutCode}, 14'h3123);
        supplyUnderLevel <= 1'b1;
        tick(FILT + 6);
        check("uvGnd", {voutGnd, voutOe, faultOe}, 3'b100);
        porLowLevel <= 1'b1;
        tick(5);
        check("porHiZ", {voutGnd, voutOe}, 2'b00);
    endtask

    initial
    begin
        t_regs();
        t_fault();
        t_clamp();
        t_ov();
        t_wrong();
        t_lock();
        t_comm();
        t_pins();
        finish_test();
    end
endmodule
